// file: rtl/osc_mode_select.sv
/*
  Oscillator mode decode, pin routing, internal source selection and
  trim settle tracking. Assumes one clock, pins split into in/out/enable,
  and configuration bits held stable by the surrounding device.
*/
// Function
// [R1] Decode three config bits into eight modes.
// [R2] Crystal modes reserve both oscillator pins.
// [R3] External clock runs from pin one, no delay.
// [R4] External clock mode: pin two is port bit six.
// [R5] RC clock-out mode drives pin two at quarter rate.
// [R6] RC I/O mode: pin two is port bit six.
// [R7] Internal clock-out: pin two quarter, pin one bit seven.
// [R8] Internal both-I/O: pins are bits seven and six.
// [R9] Fast 8 MHz source plus six-step postscaler.
// [R10] Slow source at 31.25 kHz, 32 us period.
// [R11] Slow source runs when selected or features need it.
// [R12] Frequency select chooses fast, slow or postscaler.
// [R13] Select 000 slow, 001-110 postscaler, 111 fast.
// [R14] Trim both sources, constant step, +/-12.5 percent.
// [R15] Trim is two's complement six bits.
// [R16] Slow settles in 8 cycles, fast in 1 ms.
// [R17] No completion flag; slow timing follows trim.
// [R18] Mode code mapping is a parameter.
module osc_mode_select #(
  parameter logic [23:0] MODE_MAP         = 24'hFAC688,
  parameter int          FAST_SETTLE_CLKS = osc_mode_pkg::FAST_SETTLE_CLKS
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] osc_mode_config_bits,
  input  wire logic [2:0] internal_freq_select,
  input  wire logic [5:0] trim_value,
  input  wire logic       slowSelected,
  input  wire logic       powerUpTimerEn,
  input  wire logic       watchdog_timer_en,
  input  wire logic       twoSpeedEn,
  input  wire logic       failSafeEn,
  input  wire logic       clock_pin_one_in,
  input  wire logic       porta_bit_six_out,
  input  wire logic       porta_bit_six_oe_n,
  input  wire logic       porta_bit_seven_out,
  input  wire logic       porta_bit_seven_oe_n,
  output logic            clock_pin_two_out,
  output logic            clock_pin_two_oe_n,
  output logic            clock_pin_one_out,
  output logic            clock_pin_one_oe_n,
  output logic            pinOneIsPort,
  output logic            pinTwoIsPort,
  output logic            extClockRun,
  output logic            startupDelayNeeded,
  output logic            intClockTick,
  output logic            slowClockTick,
  output logic            slowRunning,
  output logic [2:0]      modeOut
);

  osc_mode_pkg::osc_mode_t mode;       // Decoded mode.
  osc_mode_pkg::src_sel_t  srcSel;     // Internal source choice.
  logic        fastTick;               // One strobe per fast period.
  logic        slowTick;               // One strobe per slow period.
  logic        slowRun;                // Slow source enable.
  logic        quarterTick;            // Source strobe counted by the divide-by-four.
  logic        sysTick;                // Strobe of the selected source.
  logic [1:0]  div4_r, div4_nxt;       // Divide-by-four counter.
  logic        q_r, q_nxt;             // Quarter-rate square wave.
  logic [6:0]  post_r, post_nxt;       // Postscaler counter.
  logic [5:0]  trimPrev_r;             // Last trim value, for change detection.
  logic [31:0] fastWait_r, fastWait_nxt;  // Fast settle countdown.
  logic [3:0]  slowWait_r, slowWait_nxt;  // Slow settle countdown in slow cycles.
  logic        postTick;               // Postscaler output strobe.
  // Pin one level one clock ago; it resets to the low level of a stopped source,
  // so no false edge follows reset.
  logic        pinOnePrev_r;

  // Mode decode through the parameter table, first matching code wins.
  always_comb begin
    mode = osc_mode_pkg::low_power_crystal_mode;
    for (int i = 7; i >= 0; i--) begin
      if (MODE_MAP[i*3 +: 3] == osc_mode_config_bits) begin
        mode = osc_mode_pkg::osc_mode_t'(3'(i));  // [R1] [R18]
      end
    end
  end

  // Slow source runs for any feature that depends on it.
  assign slowRun = slowSelected | powerUpTimerEn | watchdog_timer_en |
                   twoSpeedEn | failSafeEn;  // [R11]

  // Both sources share the trim value, so slow timing follows it.
  trim_nco #(.NOMINAL_STEP(osc_mode_pkg::FAST_STEP)) fastSrc (  // [R9] [R14]
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (1'b1),
    .trimValue (trim_value),  // [R15]
    .tick      (fastTick)
  );
  trim_nco #(.NOMINAL_STEP(osc_mode_pkg::SLOW_STEP)) slowSrc (  // [R10] [R17]
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (slowRun),
    .trimValue (trim_value),
    .tick      (slowTick)
  );

  // Source selection from the frequency field.
  always_comb begin
    if (internal_freq_select == osc_mode_pkg::FREQ_SLOW) begin
      srcSel = osc_mode_pkg::selSlow;  // [R13]
    end else if (internal_freq_select == osc_mode_pkg::FREQ_FAST) begin
      srcSel = osc_mode_pkg::selFast;  // [R13]
    end else begin
      srcSel = osc_mode_pkg::selPost;  // [R12]
    end
  end

  // Postscaler: field 6 halves 8 MHz, each lower code halves again.
  always_comb begin
    post_nxt = fastTick ? post_r + 7'h01 : post_r;
    postTick = 1'b0;
    if (fastTick) begin
      postTick = (post_nxt & (7'(1) << (3'h7 - internal_freq_select)) - 7'h01) ==
                 7'h00;  // [R9]
    end
    case (srcSel)
      osc_mode_pkg::selSlow: sysTick = slowTick;
      osc_mode_pkg::selFast: sysTick = fastTick;
      osc_mode_pkg::selPost: sysTick = postTick;
      default:               sysTick = 1'b0;
    endcase
  end

  // Quarter-rate generator; the external RC rate is stood in by pin one edges.
  // Only the rising edge counts, since a level would advance the count every clock.
  always_comb begin
    quarterTick = (mode == osc_mode_pkg::resistor_cap_clkout_mode) ?
                  (clock_pin_one_in & ~pinOnePrev_r) : sysTick;
    div4_nxt = div4_r;
    q_nxt = q_r;
    if (quarterTick) begin
      div4_nxt = div4_r + 2'h1;
      if (div4_r[0]) begin
        q_nxt = ~q_r;  // [R5] [R7]
      end
    end
  end

  // Trim settle tracking; nothing reports completion outward.
  always_comb begin
    fastWait_nxt = (fastWait_r != 32'h0) ? fastWait_r - 32'h1 : fastWait_r;
    slowWait_nxt = (slowWait_r != 4'h0 && slowTick) ? slowWait_r - 4'h1 : slowWait_r;
    if (trim_value != trimPrev_r) begin
      fastWait_nxt = 32'(FAST_SETTLE_CLKS);  // [R16]
      slowWait_nxt = 4'(osc_mode_pkg::SLOW_SETTLE_CYC);  // [R16]
    end
  end

  // Register all state and every output.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div4_r             <= 2'h0;
      q_r                <= 1'b0;
      post_r             <= 7'h00;
      trimPrev_r         <= 6'h00;
      pinOnePrev_r       <= 1'b0;
      fastWait_r         <= 32'h0;
      slowWait_r         <= 4'h0;
      clock_pin_two_out  <= 1'b0;
      clock_pin_two_oe_n <= 1'b1;
      clock_pin_one_out  <= 1'b0;
      clock_pin_one_oe_n <= 1'b1;
      pinOneIsPort       <= 1'b0;
      pinTwoIsPort       <= 1'b0;
      extClockRun        <= 1'b0;
      startupDelayNeeded <= 1'b0;
      intClockTick       <= 1'b0;
      slowClockTick      <= 1'b0;
      slowRunning        <= 1'b0;
      modeOut            <= 3'h0;
    end else begin
      div4_r        <= div4_nxt;
      q_r           <= q_nxt;
      post_r        <= post_nxt;
      trimPrev_r    <= trim_value;
      pinOnePrev_r  <= clock_pin_one_in;  // [R5]
      fastWait_r    <= fastWait_nxt;
      slowWait_r    <= slowWait_nxt;
      intClockTick  <= sysTick;
      slowClockTick <= slowTick;
      slowRunning   <= slowRun;
      modeOut       <= 3'(mode);
      extClockRun   <= (mode == osc_mode_pkg::external_clock_io_mode);  // [R3]
      // Only crystal modes wait for the oscillator to start.
      startupDelayNeeded <= (mode == osc_mode_pkg::low_power_crystal_mode) ||
                            (mode == osc_mode_pkg::crystal_resonator_mode) ||
                            (mode == osc_mode_pkg::high_speed_crystal_mode);  // [R3]
      // Pin routing per mode; pins default to oscillator use, undriven.
      clock_pin_one_out  <= 1'b0;
      clock_pin_one_oe_n <= 1'b1;
      clock_pin_two_out  <= 1'b0;
      clock_pin_two_oe_n <= 1'b1;
      pinOneIsPort       <= 1'b0;
      pinTwoIsPort       <= 1'b0;
      case (mode)
        osc_mode_pkg::low_power_crystal_mode,
        osc_mode_pkg::crystal_resonator_mode,
        osc_mode_pkg::high_speed_crystal_mode: begin
          pinOneIsPort <= 1'b0;  // [R2]
        end
        osc_mode_pkg::resistor_cap_clkout_mode: begin
          clock_pin_two_out  <= q_nxt;  // [R5]
          clock_pin_two_oe_n <= 1'b0;
        end
        osc_mode_pkg::internal_osc_clkout_mode: begin
          clock_pin_two_out  <= q_nxt;  // [R7]
          clock_pin_two_oe_n <= 1'b0;
          pinOneIsPort       <= 1'b1;
          clock_pin_one_out  <= porta_bit_seven_out;
          clock_pin_one_oe_n <= porta_bit_seven_oe_n;
        end
        osc_mode_pkg::internal_osc_both_io_mode: begin
          pinOneIsPort       <= 1'b1;  // [R8]
          pinTwoIsPort       <= 1'b1;
          clock_pin_one_out  <= porta_bit_seven_out;
          clock_pin_one_oe_n <= porta_bit_seven_oe_n;
          clock_pin_two_out  <= porta_bit_six_out;
          clock_pin_two_oe_n <= porta_bit_six_oe_n;
        end
        osc_mode_pkg::resistor_cap_io_mode,
        osc_mode_pkg::external_clock_io_mode: begin
          pinTwoIsPort       <= 1'b1;  // [R4] [R6]
          clock_pin_two_out  <= porta_bit_six_out;
          clock_pin_two_oe_n <= porta_bit_six_oe_n;
        end
        default: begin
          pinOneIsPort <= 1'b0;
        end
      endcase
    end
  end

  // Crystal modes never hand a pin to the port.
  a_crystal_pins: assert property (@(posedge clk) disable iff (!arst_n)
    startupDelayNeeded |-> !pinOneIsPort && !pinTwoIsPort && clock_pin_two_oe_n)  // [R2]
    else $error("Crystal mode released an oscillator pin.");
  a_ext_no_delay: assert property (@(posedge clk) disable iff (!arst_n)
    extClockRun |-> !startupDelayNeeded && pinTwoIsPort && !pinOneIsPort)  // [R3] [R4]
    else $error("External clock mode routing wrong.");
  a_both_io: assert property (@(posedge clk) disable iff (!arst_n)
    modeOut == 3'(osc_mode_pkg::internal_osc_both_io_mode) |->
    pinOneIsPort && pinTwoIsPort)  // [R8]
    else $error("Both-I/O mode did not free both pins.");
  a_clkout_drive: assert property (@(posedge clk) disable iff (!arst_n)
    modeOut == 3'(osc_mode_pkg::internal_osc_clkout_mode) |->
    !clock_pin_two_oe_n && pinOneIsPort)  // [R7]
    else $error("Clock-out mode not driving pin two.");
  a_slow_enable: assert property (@(posedge clk) disable iff (!arst_n)
    (watchdog_timer_en || slowSelected) |=> slowRunning)  // [R11]
    else $error("Slow source not running when needed.");
  // The tick output lags the run flag by one register, so the check looks one clock on.
  a_slow_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    !slowRunning |=> !slowClockTick)  // [R10]
    else $error("Slow source ticked while stopped.");
  a_fast_select: assert property (@(posedge clk) disable iff (!arst_n)
    (internal_freq_select == osc_mode_pkg::FREQ_FAST) |=>
    (intClockTick == $past(fastTick)))  // [R12] [R13]
    else $error("Fast selection not routed.");
  a_trim_settle: assert property (@(posedge clk) disable iff (!arst_n)
    (trim_value != trimPrev_r) |=> slowWait_r == 4'(osc_mode_pkg::SLOW_SETTLE_CYC))  // [R16]
    else $error("Slow settle count not loaded.");
  a_fast_settle: assert property (@(posedge clk) disable iff (!arst_n)
    (trim_value != trimPrev_r) |=> fastWait_r == 32'(FAST_SETTLE_CLKS))  // [R16]
    else $error("Fast settle count not loaded.");
  c_crystal: cover property (@(posedge clk) startupDelayNeeded);
  c_ext: cover property (@(posedge clk) extClockRun);
  c_clkout: cover property (@(posedge clk) !clock_pin_two_oe_n && $rose(clock_pin_two_out));
  c_trim: cover property (@(posedge clk) trim_value != trimPrev_r);

endmodule : osc_mode_select

// file: rtl/trim_nco.sv
/*
  Trimmed phase accumulator standing for one internal source.
  Assumes one system clock domain; emits one strobe per source period.
*/
module trim_nco #(
  parameter logic [31:0] NOMINAL_STEP = 32'h00010000
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic [5:0] trimValue,
  output logic            tick
);

  logic [31:0] phase_r;    // Running phase.
  logic [31:0] phase_nxt;  // Next phase.
  logic        tick_nxt;   // Carry out marks one source period.
  logic [32:0] sum;        // Phase plus trimmed step with carry.
  logic [31:0] stepAdj;    // Trim-scaled step.
  logic signed [37:0] prod;  // Signed trim times step fraction.

  // Constant sensitivity: every trim step moves the rate by the same amount.
  always_comb begin
    prod = 38'(signed'(trimValue)) * 38'(signed'({6'h00, NOMINAL_STEP[31:0]} >>
           $clog2(osc_mode_pkg::TRIM_STEPS * 8)));
    stepAdj = NOMINAL_STEP + prod[31:0];
    sum = {1'b0, phase_r} + {1'b0, stepAdj};
    phase_nxt = run ? sum[31:0] : phase_r;
    tick_nxt = run & sum[32];
  end

  // Register the phase; a stopped source keeps its phase and stays quiet.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 32'h00000000;
      tick    <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      tick    <= tick_nxt;
    end
  end

endmodule : trim_nco

// file: shared/osc_mode_pkg.sv
/*
  Constants and types shared by the oscillator mode select logic.
  Assumes a 25 MHz system clock; all source rates are modelled as
  enable strobes derived from that clock.
*/
package osc_mode_pkg;

  // Oscillator modes in their listed order.
  typedef enum logic [2:0] {
    low_power_crystal_mode,
    crystal_resonator_mode,
    high_speed_crystal_mode,
    resistor_cap_clkout_mode,
    resistor_cap_io_mode,
    internal_osc_clkout_mode,
    internal_osc_both_io_mode,
    external_clock_io_mode
  } osc_mode_t;

  // Selection of the internal source driving the internal clock output.
  typedef enum logic [1:0] {
    selSlow,
    selPost,
    selFast
  } src_sel_t;

  localparam int          CLK_MHZ          = 25;
  localparam int          CLK_KHZ          = CLK_MHZ * 1000;
  localparam int          FAST_KHZ         = 8000;
  localparam int          SLOW_HZ          = 31250;
  localparam int          SLOW_PERIOD_US   = 32;
  localparam int          FAST_SETTLE_US   = 1000;
  localparam int          SLOW_SETTLE_CYC  = 8;
  // Fast settle time in system clocks: 1000 us at 25 clocks per us, an exact product.
  localparam int          FAST_SETTLE_CLKS = FAST_SETTLE_US * CLK_MHZ;
  // Slow settle time in system clocks: eight slow periods.
  localparam int          SLOW_SETTLE_CLKS = SLOW_SETTLE_CYC * SLOW_PERIOD_US * CLK_MHZ;
  localparam logic [2:0]  FREQ_SLOW        = 3'h0;
  localparam logic [2:0]  FREQ_FAST        = 3'h7;
  localparam logic [5:0]  TRIM_CENTRE      = 6'h00;
  localparam logic [5:0]  TRIM_MAX         = 6'h1F;
  localparam logic [5:0]  TRIM_MIN         = 6'h20;
  // Range is +/-12.5 percent, so each trim step is 12.5/32 percent.
  localparam int          TRIM_RANGE_PPT   = 125;
  localparam int          TRIM_STEPS       = 32;
  localparam int          DIV4_MAX         = 3;
  localparam int          PORTA_SIX        = 6;
  localparam int          PORTA_SEVEN      = 7;
  localparam int          PHASE_W          = 32;
  // Phase step per system clock for an 8 MHz source: 2^32 * 8 / 25.
  localparam logic [31:0] FAST_STEP        = 32'h51EB851E;
  // Phase step per system clock for a 31.25 kHz source: 2^32 * 31250 / 25000000.
  localparam logic [31:0] SLOW_STEP        = 32'h0051EB85;

endpackage : osc_mode_pkg

// file: tb/clock_source_model.sv
/*
  Behavioural external clock source that feeds oscillator pin one.
  Assumes the bench clock as time base; the half period is in bench cycles.
*/
module clock_source_model (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] halfCycles,
  output logic            pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_r;  // Bench cycles spent in the current half period.

  // Moves on the falling edge so the design never samples a moving level.
  // A stopped source stands low, as a gated oscillator would.
  always @(negedge clk) begin
    if (!run) begin
      cnt_r    <= 8'h00;
      pinLevel <= 1'b0;
    end else if (cnt_r >= halfCycles - 8'h01) begin
      cnt_r    <= 8'h00;
      pinLevel <= ~pinLevel;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : clock_source_model

// file: tb/oscillator_mode_select_tb.sv
/*
  Self-checking bench for the oscillator mode select block.
  Assumes a 25 MHz clock and a shortened fast settle count of 20 clocks.
*/
module oscillator_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0, arst_n = 1'b0;  // Clock and reset.
  logic [2:0] mode = 3'h0, freq = 3'h0;   // Mode code and frequency select.
  logic [5:0] trim = 6'h00;               // Trim value.
  logic [4:0] en = 5'h00;                 // Slow source demands.
  logic       p6o = 1'b0, p6oe = 1'b1, p7o = 1'b0, p7oe = 1'b1;
  logic       pin1, p2o, p2oe, p1o, p1oe, p1Port, p2Port, extRun, stDly;
  logic       intTick, slowTick, slowRun;
  logic [2:0] modeOut;
  int         num_errors = 0, total_checks = 0;
  int         cInt, cSlow, cTog, cRise;   // Counts from the last window.

  always #20 clk = ~clk;

  // The source is held stopped during reset so that its level starts known.
  clock_source_model src (.clk(clk), .run(arst_n), .halfCycles(8'h05), .pinLevel(pin1));

  osc_mode_select #(.FAST_SETTLE_CLKS(20)) uut (
    .clk(clk), .arst_n(arst_n), .osc_mode_config_bits(mode),
    .internal_freq_select(freq), .trim_value(trim), .slowSelected(en[0]),
    .powerUpTimerEn(en[1]), .watchdog_timer_en(en[2]), .twoSpeedEn(en[3]),
    .failSafeEn(en[4]), .clock_pin_one_in(pin1), .porta_bit_six_out(p6o),
    .porta_bit_six_oe_n(p6oe), .porta_bit_seven_out(p7o), .porta_bit_seven_oe_n(p7oe),
    .clock_pin_two_out(p2o), .clock_pin_two_oe_n(p2oe), .clock_pin_one_out(p1o),
    .clock_pin_one_oe_n(p1oe), .pinOneIsPort(p1Port), .pinTwoIsPort(p2Port),
    .extClockRun(extRun), .startupDelayNeeded(stDly), .intClockTick(intTick),
    .slowClockTick(slowTick), .slowRunning(slowRun), .modeOut(modeOut));

  task end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Compares a single output bit; case equality keeps unknowns from passing.
  task chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  // Compares a count with a tolerance, since rates are sampled over windows.
  task chk_cnt(input string name, input int exp, input int got, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  // Counts ticks, pin two toggles and pin one rises over n cycles.
  task count_win(input int n);
    logic lastTwo, lastOne;
    cInt = 0; cSlow = 0; cTog = 0; cRise = 0;
    lastTwo = p2o;
    lastOne = pin1;
    repeat (n) begin
      @(negedge clk);
      cInt += (intTick === 1'b1);
      cSlow += (slowTick === 1'b1);
      cTog += (p2o !== lastTwo);
      cRise += (pin1 === 1'b1 && lastOne === 1'b0);
      lastTwo = p2o;
      lastOne = pin1;
    end
  endtask : count_win

  // Pin roles per listed mode: {pin one port, pin two port, ext run, startup}.
  function automatic logic [3:0] cfg(input int m);
    case (m)
      0, 1, 2: return 4'h1;
      3:       return 4'h0;
      4:       return 4'h4;
      5:       return 4'h8;
      6:       return 4'hC;
      default: return 4'h6;
    endcase
  endfunction : cfg

  // Ticks expected in n cycles; one trim step is 1/256 of nominal.
  function automatic int exp_ticks(input int n, input int sel, input logic [5:0] t);
    longint hz[8] = '{31250, 125000, 250000, 500000, 1000000, 2000000, 4000000, 8000000};
    return int'(n * hz[sel] * (256 + $signed(t)) / (64'sd256 * 64'sd25000000));
  endfunction : exp_ticks

  // Watchdog sized a little above the planned run length.
  initial begin
    #(40 * 99000);
    num_errors++;
    end_sim();
  end

  initial begin
    logic [3:0] e;
    logic [5:0] tl[6];
    int         x;
    void'($urandom(93664));
    repeat (3) @(negedge clk);
    chk_bit("pinTwoOeReset", 1'b1, p2oe);
    chk_bit("pinOneOeReset", 1'b1, p1oe);
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    // Every mode code with random port traffic on the borrowed pins.
    for (int m = 0; m < 8; m++) begin
      mode = m[2:0];
      repeat (12) begin
        @(negedge clk);
        e = cfg(m);
        chk_bit("modeOut", 1'b1, modeOut === m[2:0]);
        chk_bit("pinOneIsPort", e[3], p1Port);
        chk_bit("pinTwoIsPort", e[2], p2Port);
        chk_bit("extClockRun", e[1], extRun);
        chk_bit("startupDelay", e[0], stDly);
        chk_bit("pinOneOe", e[3] ? p7oe : 1'b1, p1oe);
        chk_bit("pinTwoOe", e[2] ? p6oe : !(m == 3 || m == 5), p2oe);
        if (e[3]) chk_bit("pinOneOut", p7o, p1o);
        if (e[2]) chk_bit("pinTwoOut", p6o, p2o);
        x = $urandom;
        {p6o, p6oe, p7o, p7oe} = x[3:0];
      end
    end
    // Quarter-rate output from the RC source and from the internal clock.
    mode = 3'h3;
    repeat (4) @(negedge clk);
    count_win(800);
    chk_cnt("rcQuarterToggles", cRise / 2, cTog, 2);
    mode = 3'h5;
    freq = 3'h6;
    repeat (4) @(negedge clk);
    count_win(800);
    chk_cnt("intQuarterToggles", cInt / 2, cTog, 2);
    // Each demand alone keeps the slow source running.
    freq = 3'h7;
    for (int i = 0; i < 5; i++) begin
      en = 5'h01 << i;
      repeat (2) @(negedge clk);
      chk_bit("slowRunning", 1'b1, slowRun);
    end
    en = 5'h00;
    repeat (2) @(negedge clk);
    chk_bit("slowIdle", 1'b0, slowRun);
    // Every frequency select code measured over a window.
    en = 5'h01;
    for (int f = 0; f < 8; f++) begin
      freq = f[2:0];
      repeat (4) @(negedge clk);
      count_win(3000);
      chk_cnt("intTicks", exp_ticks(3000, f, 6'h00), cInt, 2 + cInt / 100);
    end
    chk_cnt("slowTicks", exp_ticks(3000, 0, 6'h00), cSlow, 2);
    // Trim extremes, centre and random values on the fast source.
    tl = '{6'h1F, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
    for (int k = 3; k < 6; k++) tl[k] = 6'($urandom % 64);
    for (int k = 0; k < 6; k++) begin
      trim = tl[k];
      repeat (40) @(negedge clk);
      count_win(3000);
      chk_cnt("trimTicks", exp_ticks(3000, 7, trim), cInt, 2 + cInt / 100);
    end
    // Slowest trim on the slow source after 6400 clocks, eight nominal slow periods.
    trim = 6'h20;
    repeat (6400) @(negedge clk);
    count_win(32000);
    chk_cnt("slowTrimTicks", exp_ticks(32000, 0, trim), cSlow, 2);
    end_sim();
  end
endmodule : oscillator_mode_select_tb
